// ### ejm_err_chan.sv
// One channel's live error counter and its read-back copy
`timescale 1ns/100ps
module ejm_err_chan
    import ejm_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        err_in,
    input  wire logic        update_in,
    output logic [15:0]      held_out,
    output logic             ovf_out
);
`include "ejm_regs.svh"

    ejm_chan_t s;
    ejm_chan_t n;

    always_comb begin
        n     = s;
        n.ovf = 1'b0;
        if (update_in) begin
            n.held = s.live;
            n.live = err_in ? 16'h0001 : `EJM_RST_CNT;
        end else if (err_in) begin
            // Saturate so software still sees a full count after a wrap would occur
            if (s.live == `EJM_CNT_MAX) begin
                n.ovf = 1'b1;
            end else begin
                n.live = s.live + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign held_out = s.held;
    assign ovf_out  = s.ovf;

    AST_HELD_UPDATE: assert property (@(posedge clk_in) disable iff (rst_in)
        update_in |=> (held_out == $past(s.live)))
        else $error("held count not taken from live count");

endmodule

// ### ejm_pkg.sv
// State types of the error count and jitter register block
package ejm_pkg;

    typedef struct packed {
        logic [15:0] live;
        logic [15:0] held;
        logic        ovf;
    } ejm_chan_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } ejm_tmr_t;

    typedef struct packed {
        logic        aw_have;
        logic [10:0] aw_idx;
        logic        w_have;
        logic [7:0]  w_data;
        logic        w_lane0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [7:0]  rdata;
        logic        band;
        logic        period;
        logic        close;
        logic        close_d;
        logic        cnt_sel;
        logic        cnt_upd;
        logic        win_end;
        logic [11:0] pos_peak;
        logic [11:0] neg_peak;
        logic [8:0]  ovf_stat;
        logic [8:0]  ovf_mask;
        logic        irq;
    } ejm_top_t;

endpackage

// ### ejm_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef EJM_REGS_SVH
`define EJM_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EJM_IDX_CH1_LO    11'h023
`define EJM_IDX_CH1_HI    11'h024
`define EJM_CH_STRIDE     11'h040
`define EJM_CH_LAST       11'h1E4
`define EJM_IDX_CH0_LO    11'h7E3
`define EJM_IDX_CH0_HI    11'h7E4
`define EJM_IDX_JM_CFG    11'h7E5
`define EJM_IDX_POS_LO    11'h7E6
`define EJM_IDX_POS_HI    11'h7E7
`define EJM_IDX_NEG_LO    11'h7E8
`define EJM_IDX_NEG_HI    11'h7E9
`define EJM_IDX_CNT_CTRL  11'h7F0
`define EJM_IDX_INT_STAT  11'h7F1
`define EJM_IDX_INT_MASK  11'h7F2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EJM_BIT_BAND      0
`define EJM_BIT_PERIOD    1
`define EJM_BIT_CLOSE     2
`define EJM_BIT_CNT_REQ   0
`define EJM_BIT_CNT_SEL   1

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define EJM_RST_BYTE      8'h00
`define EJM_RST_CNT       16'h0000
`define EJM_CNT_MAX       16'hFFFF
`define EJM_RESP_OKAY     2'h0
`define EJM_RESP_SLVERR   2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EJM_CLK_NS        8
`define EJM_PERIOD_NS     1000000000
`define EJM_PERIOD_CYC    (`EJM_PERIOD_NS / `EJM_CLK_NS)

`endif

// ### ejm_regs_top.sv
// Error counter and channel 0 jitter measurement register bank, AXI4-Lite slave
`timescale 1ns/100ps
`include "ejm_regs.svh"
module ejm_regs_top
    import ejm_pkg::*;
#(
    parameter int unsigned NUM_CH     = 9,
    parameter int unsigned ADDR_W     = 13,
    parameter int unsigned PERIOD_CYC = `EJM_PERIOD_CYC
) (
    input  wire logic              REF_CLK_IN,
    input  wire logic              RESET_IN,
    input  wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
    input  wire logic              AXI_AWVALID_IN,
    output logic                   AXI_AWREADY_OUT,
    input  wire logic [31:0]       AXI_WDATA_IN,
    input  wire logic [3:0]        AXI_WSTRB_IN,
    input  wire logic              AXI_WVALID_IN,
    output logic                   AXI_WREADY_OUT,
    output logic [1:0]             AXI_BRESP_OUT,
    output logic                   AXI_BVALID_OUT,
    input  wire logic              AXI_BREADY_IN,
    input  wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
    input  wire logic              AXI_ARVALID_IN,
    output logic                   AXI_ARREADY_OUT,
    output logic [31:0]            AXI_RDATA_OUT,
    output logic [1:0]             AXI_RRESP_OUT,
    output logic                   AXI_RVALID_OUT,
    input  wire logic              AXI_RREADY_IN,
    input  wire logic [NUM_CH-1:0] ERR_EVENT_IN,
    input  wire logic              COUNT_ROUND_IN,
    input  wire logic [11:0]       PEAK_POS_IN,
    input  wire logic [11:0]       PEAK_NEG_IN,
    output logic                   JITTER_BAND_OUT,
    output logic                   JITTER_WINDOW_END_OUT,
    output logic                   IRQ_OUT
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // The decode is built for exactly this map, so other channel counts and address widths below 13 are refused outright
    if (NUM_CH != 9) begin : g_bad_ch
        $error("NUM_CH must be 9: channel 0 plus eight line channels");
    end
    if (ADDR_W < 13) begin : g_bad_addr
        $error("ADDR_W must be at least 13 to reach index 0x7F2");
    end

    // ----------------------------------------------------------------
    // Per-channel error counters
    // ----------------------------------------------------------------
    ejm_top_t    s;
    ejm_top_t    n;
    logic [15:0] held_w [NUM_CH];
    logic [8:0]  ovf_w;
    logic        tick_w;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
            ejm_err_chan u_chan (
                .clk_in    (REF_CLK_IN),
                .rst_in    (RESET_IN),
                .err_in    (ERR_EVENT_IN[gi]),
                .update_in (s.cnt_upd),
                .held_out  (held_w[gi]),
                .ovf_out   (ovf_w[gi])
            );
        end
    endgenerate

    ejm_sec_timer #(
        .PERIOD_CYC (PERIOD_CYC)
    ) u_timer (
        .clk_in   (REF_CLK_IN),
        .rst_in   (RESET_IN),
        .run_in   (s.period),
        .tick_out (tick_w)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic        aw_fire;
    logic        w_fire;
    logic        ar_fire;
    logic        wr_go;
    logic [10:0] ar_idx;
    logic [10:0] ch_off;
    logic [3:0]  ch_sel;
    logic        ch_lo;
    logic        ch_hit;
    logic        win_end;

    assign aw_fire = AXI_AWVALID_IN & s.awready;
    assign w_fire  = AXI_WVALID_IN & s.wready;
    assign ar_fire = AXI_ARVALID_IN & s.arready;
    assign wr_go   = s.aw_have & s.w_have & ~s.bvalid;
    assign ar_idx  = AXI_ARADDR_IN[12:2];

    // Window end: hand-closed only in manual mode, timer-closed only in automatic mode
    assign win_end = s.period ? tick_w
                              : (s.close & ~s.close_d);

    always_comb begin
        ch_off = 11'h000;
        ch_sel = 4'h0;
        ch_lo  = 1'b0;
        ch_hit = 1'b0;
        // Line channels repeat every 0x40 from 0x023
        if ((ar_idx >= `EJM_IDX_CH1_LO) && (ar_idx <= `EJM_CH_LAST)) begin
            ch_off = ar_idx - `EJM_IDX_CH1_LO;
            if ((ch_off[5:0] == 6'h00) || (ch_off[5:0] == 6'h01)) begin
                ch_hit = 1'b1;
                ch_lo  = (ch_off[5:0] == 6'h00);
                ch_sel = {1'b0, ch_off[8:6]} + 4'h1;
            end
        end else if ((ar_idx == `EJM_IDX_CH0_LO) || (ar_idx == `EJM_IDX_CH0_HI)) begin
            ch_hit = 1'b1;
            ch_lo  = (ar_idx == `EJM_IDX_CH0_LO);
            ch_sel = 4'h0;
        end
    end

    always_comb begin
        n         = s;
        n.close_d = s.close;
        n.cnt_upd = s.cnt_sel ? 1'b0 : COUNT_ROUND_IN;
        n.win_end = win_end;

        // Write channel: address and data taken in either order
        if (aw_fire) begin
            n.aw_have = 1'b1;
            n.aw_idx  = AXI_AWADDR_IN[12:2];
        end
        if (w_fire) begin
            n.w_have  = 1'b1;
            n.w_data  = AXI_WDATA_IN[7:0];
            n.w_lane0 = AXI_WSTRB_IN[0];
        end
        if (s.bvalid && AXI_BREADY_IN) begin
            n.bvalid = 1'b0;
        end

        n.ovf_stat = s.ovf_stat;
        if (wr_go) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `EJM_RESP_OKAY;
            if (s.aw_idx == `EJM_IDX_JM_CFG) begin
                if (s.w_lane0) begin
                    n.band   = s.w_data[`EJM_BIT_BAND];
                    n.period = s.w_data[`EJM_BIT_PERIOD];
                    n.close  = s.w_data[`EJM_BIT_CLOSE];
                end
            end else if (s.aw_idx == `EJM_IDX_CNT_CTRL) begin
                if (s.w_lane0) begin
                    n.cnt_sel = s.w_data[`EJM_BIT_CNT_SEL];
                    if (s.w_data[`EJM_BIT_CNT_REQ] && s.w_data[`EJM_BIT_CNT_SEL]) begin
                        n.cnt_upd = 1'b1;
                    end
                end
            end else if (s.aw_idx == `EJM_IDX_INT_STAT) begin
                if (s.w_lane0) begin
                    n.ovf_stat = s.ovf_stat & ~{1'b0, s.w_data};
                end
            end else if (s.aw_idx == `EJM_IDX_INT_MASK) begin
                // One byte holds nine enables: bit 7 also enables channel 8
                if (s.w_lane0) begin
                    n.ovf_mask = {s.w_data[7], s.w_data};
                end
            end else if ((s.aw_idx >= `EJM_IDX_CH1_LO && s.aw_idx <= `EJM_CH_LAST)
                         || s.aw_idx == `EJM_IDX_CH0_LO || s.aw_idx == `EJM_IDX_CH0_HI
                         || (s.aw_idx >= `EJM_IDX_POS_LO && s.aw_idx <= `EJM_IDX_NEG_HI))
            begin
                // Read-only bytes ignore writes
                n.bresp = `EJM_RESP_OKAY;
            end else begin
                n.bresp = `EJM_RESP_SLVERR;
            end
        end
        // Set wins over a clear in the same cycle
        n.ovf_stat = n.ovf_stat | ovf_w;
        n.awready  = ~n.aw_have;
        n.wready   = ~n.w_have;

        // Read channel: one read at a time, data registered
        if (s.rvalid && AXI_RREADY_IN) begin
            n.rvalid = 1'b0;
        end
        if (ar_fire) begin
            n.rvalid = 1'b1;
            n.rresp  = `EJM_RESP_OKAY;
            n.rdata  = `EJM_RST_BYTE;
            if (ch_hit) begin
                n.rdata = ch_lo ? held_w[ch_sel][7:0] : held_w[ch_sel][15:8];
            end else if (ar_idx == `EJM_IDX_JM_CFG) begin
                n.rdata = {5'h00, s.close, s.period, s.band};
            end else if (ar_idx == `EJM_IDX_POS_LO) begin
                n.rdata = s.pos_peak[7:0];
            end else if (ar_idx == `EJM_IDX_POS_HI) begin
                n.rdata = {4'h0, s.pos_peak[11:8]};
            end else if (ar_idx == `EJM_IDX_NEG_LO) begin
                n.rdata = s.neg_peak[7:0];
            end else if (ar_idx == `EJM_IDX_NEG_HI) begin
                n.rdata = {4'h0, s.neg_peak[11:8]};
            end else if (ar_idx == `EJM_IDX_CNT_CTRL) begin
                n.rdata = {6'h00, s.cnt_sel, 1'b0};
            end else if (ar_idx == `EJM_IDX_INT_STAT) begin
                n.rdata = s.ovf_stat[7:0] | {s.ovf_stat[8], 7'h00};
            end else if (ar_idx == `EJM_IDX_INT_MASK) begin
                n.rdata = s.ovf_mask[7:0];
            end else begin
                n.rresp = `EJM_RESP_SLVERR;
            end
        end
        n.arready = ~n.rvalid;

        // Peak results: value is UIpp times sixteen, held as delivered
        if (win_end) begin
            n.pos_peak = PEAK_POS_IN;
            n.neg_peak = PEAK_NEG_IN;
        end

        n.irq = |(n.ovf_stat & n.ovf_mask);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign AXI_AWREADY_OUT       = s.awready;
    assign AXI_WREADY_OUT        = s.wready;
    assign AXI_BVALID_OUT        = s.bvalid;
    assign AXI_BRESP_OUT         = s.bresp;
    assign AXI_ARREADY_OUT       = s.arready;
    assign AXI_RVALID_OUT        = s.rvalid;
    assign AXI_RRESP_OUT         = s.rresp;
    assign AXI_RDATA_OUT         = {24'h000000, s.rdata};
    assign JITTER_BAND_OUT       = s.band;
    assign JITTER_WINDOW_END_OUT = s.win_end;
    assign IRQ_OUT               = s.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_close_rise;
        !s.period && s.close && !s.close_d;
    endsequence

    sequence s_rd_ph;
        ar_fire && (ar_idx == `EJM_IDX_POS_HI);
    endsequence

    AST_RD_ANSWER: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        ar_fire |=> AXI_RVALID_OUT && !AXI_ARREADY_OUT)
        else $error("read not answered one cycle after address");

    AST_RD_HOLD: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT))
        else $error("read data dropped before taken");

    // ----------------------------------------------------------------
    // Jitter window, overflow and count round checks
    // ----------------------------------------------------------------
    AST_MANUAL_LATCH: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        s_close_rise |=> (s.pos_peak == $past(PEAK_POS_IN)) && JITTER_WINDOW_END_OUT)
        else $error("manual window close did not latch peaks");

    AST_AUTO_IGNORES_CLOSE: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        s.period && !tick_w |=> $stable(s.pos_peak) && !JITTER_WINDOW_END_OUT)
        else $error("peak changed in automatic mode without a second tick");

    AST_AUTO_TICK: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        s.period && tick_w |=> s.neg_peak == $past(PEAK_NEG_IN))
        else $error("second tick did not latch peaks");

    AST_POS_HIGH_READ: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        s_rd_ph |=> AXI_RDATA_OUT == {24'h000000, 4'h0, $past(s.pos_peak[11:8])})
        else $error("positive peak high byte read wrong");

    AST_OVF_IRQ: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        |(ovf_w & s.ovf_mask) |=> IRQ_OUT && |s.ovf_stat)
        else $error("unmasked overflow did not raise interrupt");

    AST_OVF_STICKY: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        s.ovf_stat[0] && !(wr_go && s.aw_idx == `EJM_IDX_INT_STAT) |=> s.ovf_stat[0])
        else $error("overflow flag cleared without a write");

    AST_AUTO_ROUND: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        COUNT_ROUND_IN && !s.cnt_sel |=> s.cnt_upd)
        else $error("automatic count round not applied");

    AST_MANUAL_ROUND: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        COUNT_ROUND_IN && s.cnt_sel && !wr_go |=> !s.cnt_upd)
        else $error("count round applied while manual update is selected");

    AST_OVF_SET_WINS: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        |ovf_w |=> ((s.ovf_stat & $past(ovf_w)) == $past(ovf_w)))
        else $error("overflow event lost against a clear");

    AST_OVF_CLEAR: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        wr_go && (s.aw_idx == `EJM_IDX_INT_STAT) && s.w_lane0 && s.w_data[0] && !ovf_w[0]
        |=> !s.ovf_stat[0])
        else $error("writing one did not clear the overflow flag");

    // ----------------------------------------------------------------
    // Bus, configuration and window pulse checks
    // ----------------------------------------------------------------
    sequence s_wr_pair;
        s.aw_have && s.w_have && !s.bvalid;
    endsequence

    sequence s_cfg_write;
        wr_go && (s.aw_idx == `EJM_IDX_JM_CFG) && s.w_lane0;
    endsequence

    AST_WR_ANSWER: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        s_wr_pair |=> AXI_BVALID_OUT && AXI_AWREADY_OUT && AXI_WREADY_OUT)
        else $error("write not answered one cycle after address and data held");

    AST_WR_HOLD: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
        else $error("write response dropped before taken");

    AST_RD_UNMAPPED: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        ar_fire && (ar_idx < `EJM_IDX_CH1_LO) |=> AXI_RRESP_OUT == `EJM_RESP_SLVERR)
        else $error("read below the counter map not refused");

    AST_CFG_BAND: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        s_cfg_write |=> JITTER_BAND_OUT == $past(s.w_data[`EJM_BIT_BAND]))
        else $error("band select not taken from configuration write");

    AST_WIN_SINGLE: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        JITTER_WINDOW_END_OUT |=> !JITTER_WINDOW_END_OUT)
        else $error("window end pulse longer than one cycle");

endmodule

// ### ejm_regs_top_bench.sv
// Self-checking bench for the error count and jitter register bank
`timescale 1ns/100ps
`include "ejm_regs.svh"
module ejm_regs_top_bench;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk = 1'b0, rst = 1'b1, round = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [12:0] awaddr = 13'h0000, araddr = 13'h0000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  wstrb = 4'h0;
    logic [8:0]  err = 9'h000;
    logic [11:0] ppos = 12'h000, pneg = 12'h000;
    logic        awr, wr_rdy, bv, arr, rv, band, wend, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] ev;
    int          fail_count = 0, checked = 0, pulses = 0, cyc = 0, p0, c0;

    always #4 clk = ~clk;
    // Pulses counted at mid-cycle, where the registered strobe is settled
    always @(negedge clk) pulses <= pulses + int'(wend === 1'b1);
    always @(posedge clk) cyc <= cyc + 1;

    // Short period keeps the one-second mode inside a brief run
    ejm_regs_top #(.PERIOD_CYC(20)) DUT (
        .REF_CLK_IN(clk), .RESET_IN(rst),
        .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
        .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wv),
        .AXI_WREADY_OUT(wr_rdy), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bv),
        .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arv),
        .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
        .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rready), .ERR_EVENT_IN(err),
        .COUNT_ROUND_IN(round), .PEAK_POS_IN(ppos), .PEAK_NEG_IN(pneg),
        .JITTER_BAND_OUT(band), .JITTER_WINDOW_END_OUT(wend), .IRQ_OUT(irq)
    );

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [10:0] i, input logic [7:0] d, input logic [1:0] e);
        int         n;
        logic       a, w, v;
        logic [1:0] r, rs;
        n = 0;
        @(posedge clk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h000000, d};
        wstrb <= 4'h1;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        while (n < 50) begin
            // Handshakes are read at mid-cycle, where the design's outputs are settled
            @(negedge clk);
            {a, w, v, rs} = {awr, wr_rdy, bv, bresp};
            @(posedge clk);
            n++;
            if (awv && a) awv <= 1'b0;
            if (wv && w) wv <= 1'b0;
            if (v && bready) begin
                r = rs;
                bready <= 1'b0;
                n = 99;
            end
        end
        chk("write answer", 1, n == 99);
        chk($sformatf("bresp %0h", i), e, r);
    endtask

    task automatic rd(input logic [10:0] i, input logic [7:0] e, input logic [1:0] er);
        int          n;
        logic        a, v;
        logic [31:0] d, ds;
        logic [1:0]  r, rs;
        n = 0;
        @(posedge clk);
        araddr <= {i, 2'h0};
        arv <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(negedge clk);
            {a, v, ds, rs} = {arr, rv, rdata, rresp};
            @(posedge clk);
            n++;
            if (arv && a) arv <= 1'b0;
            if (v && rready) begin
                d = ds;
                r = rs;
                rready <= 1'b0;
                n = 99;
            end
        end
        chk("read answer", 1, n == 99);
        chk($sformatf("rresp %0h", i), er, r);
        chk($sformatf("rdata %0h", i), {24'h000000, e}, d);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic rnd;
        @(posedge clk);
        round <= 1'b1;
        @(posedge clk);
        round <= 1'b0;
        tick(3);
    endtask

    task automatic errs(input logic [8:0] m, input int n);
        repeat (n) begin
            @(posedge clk);
            err <= m;
        end
        @(posedge clk);
        err <= 9'h000;
    endtask

    function automatic logic [10:0] chx(input int k);
        return (k == 0) ? `EJM_IDX_CH0_LO : 11'(`EJM_IDX_CH1_LO + `EJM_CH_STRIDE * (k - 1));
    endfunction

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        tick(2);
        rst <= 1'b0;
        rd(`EJM_IDX_CH0_LO, 8'h00, 2'h0);
        rd(`EJM_IDX_CH1_HI, 8'h00, 2'h0);
        rd(`EJM_IDX_JM_CFG, 8'h00, 2'h0);
        rd(`EJM_IDX_POS_HI, 8'h00, 2'h0);
        // Each channel gets a distinct total, the last two above a byte
        for (int c = 0; c < 321; c++) begin
            @(posedge clk);
            for (int k = 0; k < 9; k++) err[k] <= (c < 1 + 40 * k);
        end
        errs(9'h000, 0);
        rnd();
        for (int k = 0; k < 9; k++) begin
            ev = 16'(1 + 40 * k);
            rd(chx(k), ev[7:0], 2'h0);
            rd(chx(k) + 11'h001, ev[15:8], 2'h0);
        end
        wr(chx(1), 8'hFF, 2'h0);
        rd(chx(1), 8'h29, 2'h0);
        rnd();
        rd(chx(8), 8'h00, 2'h0);
        wr(`EJM_IDX_CNT_CTRL, 8'h02, 2'h0);
        errs(9'h001, 3);
        rnd();
        rd(chx(0), 8'h00, 2'h0);
        wr(`EJM_IDX_CNT_CTRL, 8'h03, 2'h0);
        tick(3);
        rd(chx(0), 8'h03, 2'h0);
        wr(`EJM_IDX_CNT_CTRL, 8'h00, 2'h0);
        rnd();
        // Overflow needs the full 16-bit range, the longest part of the run
        errs(9'h001, 65535);
        rd(`EJM_IDX_INT_STAT, 8'h00, 2'h0);
        errs(9'h001, 1);
        tick(3);
        rd(`EJM_IDX_INT_STAT, 8'h01, 2'h0);
        chk("irq masked", 0, irq);
        wr(`EJM_IDX_INT_MASK, 8'h01, 2'h0);
        tick(2);
        chk("irq", 1, irq);
        rnd();
        rd(`EJM_IDX_CH0_HI, 8'hFF, 2'h0);
        wr(`EJM_IDX_INT_STAT, 8'h01, 2'h0);
        tick(2);
        chk("irq cleared", 0, irq);
        rd(`EJM_IDX_INT_STAT, 8'h00, 2'h0);
        ppos <= 12'hA5C;
        pneg <= 12'h3C1;
        wr(`EJM_IDX_JM_CFG, 8'h04, 2'h0);
        tick(2);
        rd(`EJM_IDX_POS_LO, 8'h5C, 2'h0);
        rd(`EJM_IDX_POS_HI, 8'h0A, 2'h0);
        rd(`EJM_IDX_NEG_LO, 8'hC1, 2'h0);
        rd(`EJM_IDX_JM_CFG, 8'h04, 2'h0);
        ppos <= 12'h123;
        wr(`EJM_IDX_JM_CFG, 8'h04, 2'h0);
        tick(2);
        rd(`EJM_IDX_POS_LO, 8'h5C, 2'h0);
        wr(`EJM_IDX_JM_CFG, 8'h00, 2'h0);
        wr(`EJM_IDX_JM_CFG, 8'h04, 2'h0);
        tick(2);
        rd(`EJM_IDX_POS_HI, 8'h01, 2'h0);
        wr(`EJM_IDX_JM_CFG, 8'h01, 2'h0);
        tick(2);
        chk("band", 1, band);
        ppos <= 12'hFFF;
        wr(`EJM_IDX_JM_CFG, 8'h02, 2'h0);
        chk("band", 0, band);
        p0 = pulses;
        c0 = cyc;
        wr(`EJM_IDX_JM_CFG, 8'h06, 2'h0);
        wr(`EJM_IDX_JM_CFG, 8'h02, 2'h0);
        wr(`EJM_IDX_JM_CFG, 8'h06, 2'h0);
        while (cyc - c0 < 100) @(posedge clk);
        chk("window ends", 4, pulses - p0);
        @(posedge clk);
        chk("window ends", 5, pulses - p0);
        rd(`EJM_IDX_POS_HI, 8'h0F, 2'h0);
        rd(11'h000, 8'h00, 2'h2);
        wr(11'h000, 8'h5A, 2'h2);
        tally_and_finish();
    end

    // Run needs about 66000 cycles, mostly the overflow fill
    initial begin
        tick(90000);
        fail_count++;
        tally_and_finish();
    end
endmodule

// ### ejm_sec_timer.sv
// One-second period timer for the automatic jitter window
`timescale 1ns/100ps
module ejm_sec_timer
    import ejm_pkg::*;
#(
    parameter int unsigned PERIOD_CYC = 125000000
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        run_in,
    output logic             tick_out
);

    // A period shorter than two cycles would leave the tick stuck high
    if (PERIOD_CYC < 2) begin : g_bad_period
        $error("PERIOD_CYC must be at least 2");
    end

    ejm_tmr_t s;
    ejm_tmr_t n;

    always_comb begin
        n      = s;
        n.tick = 1'b0;
        // Restart from zero whenever manual mode is chosen
        if (!run_in) begin
            n.cnt = 32'h0000_0000;
        end else if (s.cnt == 32'(PERIOD_CYC - 1)) begin
            n.cnt  = 32'h0000_0000;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick_out = s.tick;

endmodule
